/* core/sbwm_lane_mask.sv */
/*
  Expands the active-low byte write selects of one beat into a per-bit
  store mask and merges new data with the old word.
  Assumes the narrow width uses lanes 0 and 1 only.
*/
`timescale 1ns/10ps
module sbwm_lane_mask (
  input  wire logic                            wide,
  input  wire logic [sbwm_pkg::LANES_MAX-1:0]  selN,
  input  wire logic [sbwm_pkg::DATA_W-1:0]     newData,
  input  wire logic [sbwm_pkg::DATA_W-1:0]     oldData,
  output logic      [sbwm_pkg::DATA_W-1:0]     bitMask,
  output logic      [sbwm_pkg::DATA_W-1:0]     merged
);
  import sbwm_pkg::*;

  genvar gl;
  generate
    for (gl = 0; gl < LANES_MAX; gl++) begin : g_lane
      logic laneOn;
      // Each select enables only its own lane; upper lanes absent when narrow
      assign laneOn = ~selN[gl] & (wide | (gl < 2));
      assign bitMask[gl*LANE_W +: LANE_W] = {LANE_W{laneOn}};
      assign merged[gl*LANE_W +: LANE_W] = laneOn ? newData[gl*LANE_W +: LANE_W]
                                                  : oldData[gl*LANE_W +: LANE_W];
    end
  endgenerate

endmodule : sbwm_lane_mask

/* core/sbwm_pkg.sv */
/*
  Package for the byte-lane write masking block: widths, lane layout,
  burst timing and the carrier structs shared by the two modules.
  Assumes a single clock domain at mclk.
*/
package sbwm_pkg;

  localparam int unsigned LANE_W     = 9;
  localparam int unsigned LANES_MAX  = 4;
  localparam int unsigned DATA_W     = LANE_W * LANES_MAX;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned BEAT_W     = 2;
  localparam int unsigned BURST_LEN  = 4;
  localparam logic [1:0]  BEAT_FIRST = 2'h0;
  localparam logic [1:0]  BEAT_LAST  = 2'h3;
  localparam logic        WIDE_RST   = 1'b1;

  typedef struct packed {
    logic                 edgeNeg;   // 1: complement clock edge, 0: positive edge
    logic [LANES_MAX-1:0] selN;      // Active-low byte write selects
    logic [DATA_W-1:0]    data;
  } sbwm_beat_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] laneMask;     // Per-bit store enable
  } sbwm_wr_t;

endpackage : sbwm_pkg

/* core/sbwm_write_port.sv */
/*
  Write port of a burst SRAM with byte-lane masking. Holds a small array,
  takes write starts on positive edges and four data beats over the next
  two cycles, each on a positive or complement edge, and stores only the
  lanes whose select is low.
  Assumes both data edges are presented as beats in mclk, one per cycle,
  with beat.edgeNeg naming the edge, and inputs synchronous to mclk.
*/
// Behaviour
// - narrow, both selects low store eighteen bits
// - narrow, select zero only stores low lane
// - narrow, select one only stores upper lane
// - narrow, both selects high store nothing
// - wide, all selects low store all bits
// - wide, select zero stores bits 8:0
// - wide, select one stores bits 17:9
// - wide, select two stores bits 26:18
// - wide, select three stores bits 35:27
// - wide, all selects high store nothing
// - selects evaluated afresh at every data edge
// - masking only inside properly started writes
// - start on positive edge, four beats follow
// - data and selects registered on both edges
// - back-to-back start requests are ignored
`timescale 1ns/10ps
module sbwm_write_port (
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  input  wire logic                         clkEn,
  input  wire logic                         wide,
  input  wire logic                         write_port_select_n,
  input  wire logic [sbwm_pkg::ADDR_W-1:0]  wrAddr,
  input  wire logic                         beatValid,
  input  wire sbwm_pkg::sbwm_beat_t         beat,
  input  wire logic [sbwm_pkg::ADDR_W-1:0]  rdAddr,
  output logic      [sbwm_pkg::DATA_W-1:0]  rdData,
  output logic                              wrBusy,
  output logic                              wrDone
);
  import sbwm_pkg::*;

  typedef enum logic [1:0] {
    SBWM_IDLE  = 2'b00,
    SBWM_START = 2'b01,
    SBWM_DATA  = 2'b10
  } sbwm_state_t;

  sbwm_state_t          state_r, state_nxt;
  logic [ADDR_W-1:0]    baseAddr_r;
  logic [BEAT_W-1:0]    beatIdx_r;
  logic                 wide_r;
  logic                 prevStart_r;
  sbwm_beat_t           beat_r;
  logic                 beatHit_r;
  logic [DATA_W-1:0]    mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0]    wordAddr;
  logic [DATA_W-1:0]    bitMask;
  logic [DATA_W-1:0]    merged;
  logic                 startReq;
  logic                 beatTake;

  // A start right after a start is dropped
  assign startReq = ~write_port_select_n & ~prevStart_r & (state_r == SBWM_IDLE);
  // Beats count only inside a started write; positive edge beats 0,2
  assign beatTake = beatValid & (state_r != SBWM_IDLE)
                  & (beat.edgeNeg == beatIdx_r[0]);
  assign wordAddr = baseAddr_r + ADDR_W'(beatIdx_r);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wide_r <= WIDE_RST;
    end else if (clkEn && state_r == SBWM_IDLE) begin
      wide_r <= wide;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SBWM_IDLE:  if (startReq) state_nxt = SBWM_START;
      SBWM_START: state_nxt = SBWM_DATA;
      SBWM_DATA:  if (beatTake && beatIdx_r == BEAT_LAST) state_nxt = SBWM_IDLE;
      default:    state_nxt = SBWM_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= SBWM_IDLE;
      prevStart_r <= 1'b0;
      baseAddr_r  <= '0;
    end else if (clkEn) begin
      state_r     <= state_nxt;
      prevStart_r <= ~write_port_select_n;
      if (startReq) baseAddr_r <= wrAddr;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      beatIdx_r <= BEAT_FIRST;
      beat_r    <= '0;
      beatHit_r <= 1'b0;
    end else if (clkEn) begin
      beatHit_r <= beatTake;
      if (startReq) beatIdx_r <= BEAT_FIRST;
      else if (beatTake) beatIdx_r <= beatIdx_r + 2'h1;
      if (beatTake) beat_r <= beat;
    end
  end

  logic [ADDR_W-1:0] storeAddr_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) storeAddr_r <= '0;
    else if (clkEn && beatTake) storeAddr_r <= wordAddr;
  end

  sbwm_lane_mask u_mask (
    .wide    (wide_r),
    .selN    (beat_r.selN),
    .newData (beat_r.data),
    .oldData (mem[storeAddr_r]),
    .bitMask (bitMask),
    .merged  (merged)
  );

  // Read-modify-write keeps unselected lanes
  always_ff @(posedge mclk) begin
    if (clkEn && beatHit_r) mem[storeAddr_r] <= merged;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= '0;
      wrBusy <= 1'b0;
      wrDone <= 1'b0;
    end else if (clkEn) begin
      rdData <= wide_r ? mem[rdAddr] : {{(DATA_W/2){1'b0}}, mem[rdAddr][DATA_W/2-1:0]};
      wrBusy <= (state_nxt != SBWM_IDLE);
      wrDone <= beatTake && beatIdx_r == BEAT_LAST;
    end
  end

  sequence s_allHigh;
    beatHit_r && (&beat_r.selN[1:0]) && (!wide_r || &beat_r.selN);
  endsequence

  sequence s_beatStored;
    clkEn && beatHit_r;
  endsequence

  sequence s_narrowFull;
    !wide_r && (beat_r.selN[1:0] == 2'h0);
  endsequence

  sequence s_wideFull;
    wide_r && (beat_r.selN == 4'h0);
  endsequence

  chk_none_stored: assert property (@(posedge mclk) disable iff (!rst_b)
    s_allHigh |-> bitMask == '0) else $error("masked beat stored data");
  chk_narrow_lanes: assert property (@(posedge mclk) disable iff (!rst_b)
    !wide_r |-> bitMask[DATA_W-1:DATA_W/2] == '0) else $error("narrow wrote upper");
  chk_lane_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    bitMask[0] == ~beat_r.selN[0]) else $error("lane zero mask wrong");
  chk_lane_three: assert property (@(posedge mclk) disable iff (!rst_b)
    bitMask[DATA_W-1] == (wide_r & ~beat_r.selN[3])) else $error("lane three wrong");
  chk_merge_keep: assert property (@(posedge mclk) disable iff (!rst_b)
    s_beatStored |-> (merged & ~bitMask) == (mem[storeAddr_r] & ~bitMask))
    else $error("kept lane changed");
  chk_lane_one: assert property (@(posedge mclk) disable iff (!rst_b)
    bitMask[LANE_W] == ~beat_r.selN[1]) else $error("lane one mask wrong");
  chk_lane_two: assert property (@(posedge mclk) disable iff (!rst_b)
    bitMask[2*LANE_W] == (wide_r & ~beat_r.selN[2])) else $error("lane two mask wrong");
  chk_narrow_full: assert property (@(posedge mclk) disable iff (!rst_b)
    s_beatStored and s_narrowFull |-> merged[2*LANE_W-1:0] == beat_r.data[2*LANE_W-1:0])
    else $error("narrow full word not stored");
  chk_wide_full: assert property (@(posedge mclk) disable iff (!rst_b)
    s_beatStored and s_wideFull |-> merged == beat_r.data)
    else $error("wide full word not stored");
  chk_start_busy: assert property (@(posedge mclk) disable iff (!rst_b)
    clkEn && startReq |=> wrBusy) else $error("busy missing after start");
  chk_beat_reg: assert property (@(posedge mclk) disable iff (!rst_b)
    clkEn && beatTake |=> beat_r == $past(beat)) else $error("beat not registered");
  chk_no_stray: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == SBWM_IDLE |-> !beatTake) else $error("beat outside write");
  chk_back_start: assert property (@(posedge mclk) disable iff (!rst_b)
    clkEn && startReq |=> !startReq) else $error("second start taken");
  chk_burst_end: assert property (@(posedge mclk) disable iff (!rst_b)
    clkEn && wrDone |-> beatIdx_r == BEAT_FIRST) else $error("burst count wrong");

endmodule : sbwm_write_port

/* testbench/sbwm_byte_write_mask_tb.sv */
/* Self-checking bench for the masked write port.
   Assumes the controller model in the same folder. */
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module sbwm_byte_write_mask_tb;
  import sbwm_pkg::*;
  logic mclk = 1'b0, rst_b = 1'b0, wide = 1'b0, go = 1'b0, noStart = 1'b0, twoStarts = 1'b0;
  logic [ADDR_W-1:0] base = '0, wrAddr, rdAddr = '0;
  logic [15:0]       sels = '0;
  logic [143:0]      words = '0;
  logic              wpsN, beatValid, wrDone;
  logic [DATA_W-1:0] rdData;
  sbwm_beat_t        beat;
  logic [35:0]       expMem [256];
  int                num_errors = 0, samples_checked = 0;
  localparam logic [143:0] W1 = {36'h111111111, 36'h222222222, 36'h333333333, 36'h444444444};
  always #25 mclk = ~mclk;
  sbwm_ctrl_model sbwm_ctrl_model_i (.mclk(mclk), .go(go), .noStart(noStart),
    .twoStarts(twoStarts), .base(base),
    .sels(sels), .words(words), .write_port_select_n(wpsN), .wrAddr(wrAddr),
    .beatValid(beatValid), .beat(beat));
  sbwm_write_port sbwm_write_port_i (.mclk(mclk), .rst_b(rst_b), .clkEn(1'b1), .wide(wide),
    .write_port_select_n(wpsN), .wrAddr(wrAddr), .beatValid(beatValid), .beat(beat),
    .rdAddr(rdAddr), .rdData(rdData), .wrBusy(), .wrDone(wrDone));
  task automatic give_verdict;
    $display("Checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Expected word: each low select stores its own lane, selects 2 and 3 only when wide
  function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] n, logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (!s[i] && (wide || i < 2)) o[9*i +: 9] = n[9*i +: 9];
    return o;
  endfunction : mrg
  task automatic burst(input logic [7:0] a, input logic [15:0] s, input logic [143:0] w);
    int n;
    base  <= a;
    sels  <= s;
    words <= w;
    go    <= 1'b1;
    @(negedge mclk);
    go <= 1'b0;
    n = 0;
    while (n < 12 && !(wrDone === 1'b1)) begin
      @(negedge mclk);
      n++;
    end
    if (n == 12 && !noStart) begin
      num_errors++;
      give_verdict();
    end
    for (int k = 0; k < 4; k++) begin
      if (!noStart) expMem[a+k] = mrg(expMem[a+k], w[36*k +: 36], s[4*k +: 4]);
      rdAddr <= a + k[7:0];
      @(negedge mclk);
      @(negedge mclk);
      `CHECK("word", wide ? expMem[a+k] : {18'h0, expMem[a+k][17:0]}, rdData)
    end
  endtask : burst
  task automatic narrow_masks;
    // Fill whole words first so kept upper lanes hold known data
    wide <= 1'b1;
    burst(8'h10, 16'h0000, ~W1);
    wide <= 1'b0;
    burst(8'h10, 16'h0000, W1);
    burst(8'h10, 16'hcfde, ~W1);
  endtask : narrow_masks
  task automatic wide_masks;
    wide <= 1'b1;
    burst(8'h40, 16'h0000, W1);
    burst(8'h40, 16'h7bde, ~W1);
    burst(8'h40, 16'hf5af, W1);
  endtask : wide_masks
  task automatic stray_beats;
    noStart <= 1'b1;
    burst(8'h40, 16'h0000, ~W1);
    noStart <= 1'b0;
  endtask : stray_beats
  task automatic back_to_back;
    twoStarts <= 1'b1;
    burst(8'h80, 16'h0000, W1);
    twoStarts <= 1'b0;
  endtask : back_to_back
  initial begin
    repeat (3) @(negedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    narrow_masks();
    wide_masks();
    stray_beats();
    back_to_back();
    give_verdict();
  end
endmodule : sbwm_byte_write_mask_tb

/* testbench/sbwm_ctrl_model.sv */
/* Controller model: one write start (none with noStart, a second one with twoStarts), then four beats on alternating edges.
   Assumes bench inputs change at the falling edge of mclk. */
`timescale 1ns/10ps
module sbwm_ctrl_model (
  input  wire logic                          mclk,
  input  wire logic                          go,
  input  wire logic                          noStart,
  input  wire logic                          twoStarts,
  input  wire logic [sbwm_pkg::ADDR_W-1:0]   base,
  input  wire logic [15:0]                   sels,
  input  wire logic [143:0]                  words,
  output logic                               write_port_select_n,
  output logic      [sbwm_pkg::ADDR_W-1:0]   wrAddr,
  output logic                               beatValid,
  output sbwm_pkg::sbwm_beat_t               beat
);
  import sbwm_pkg::*;
  initial begin
    write_port_select_n = 1'b1;
    wrAddr              = '0;
    beatValid           = 1'b0;
    beat                = '0;
  end
  always @(posedge mclk) begin
    if (go) begin
      @(negedge mclk);
      write_port_select_n <= noStart;
      wrAddr              <= base;
      for (int k = 0; k < 4; k++) begin
        @(negedge mclk);
        write_port_select_n <= !(twoStarts && k == 0);
        beatValid           <= 1'b1;
        beat <= '{k[0], sels[4*k +: 4], words[36*k +: 36]};
      end
      @(negedge mclk);
      beatValid <= 1'b0;
      beat.data <= ~beat.data;
      wrAddr    <= ~wrAddr;
    end
  end
endmodule : sbwm_ctrl_model
